// ===== rtl/eph_pkg.sv
// Purpose: Shared constants and types for the energy pause command handler
// Assumes: APB slave, 32-bit data, one clock
// Notes:   Register offsets are byte addresses of aligned words
`default_nettype none
package eph_pkg;
	// Register byte offsets
	localparam logic [7:0] OFF_CONFIG    = 8'h00;
	localparam logic [7:0] OFF_COMMAND   = 8'h04;
	localparam logic [7:0] OFF_STATUS    = 8'h08;
	localparam logic [7:0] OFF_PAUSE_DUR = 8'h0C;
	localparam logic [7:0] OFF_MIN_PAUSE = 8'h10;
	localparam logic [7:0] OFF_MAX_PAUSE = 8'h14;
	localparam logic [7:0] OFF_INH_SEL   = 8'h18;
	localparam logic [7:0] OFF_POWER     = 8'h1C;
	localparam logic [7:0] OFF_PFACTOR   = 8'h20;
	localparam logic [7:0] OFF_ENERGY    = 8'h24;
	localparam logic [7:0] OFF_MEAS_ID   = 8'h28;
	localparam logic [7:0] OFF_MEAS_VAL  = 8'h2C;
	localparam logic [7:0] OFF_IRQ_STAT  = 8'h30;
	localparam logic [7:0] OFF_IRQ_EN    = 8'h34;
	localparam logic [7:0] OFF_IRQ_CLR   = 8'h38;

	// Configuration bit positions
	localparam int CFG_DISABLE_BIT = 0;
	localparam int CFG_RAMP_BIT    = 1;
	localparam int CFG_S4_BIT      = 2;
	localparam logic [2:0] CFG_RESET = 3'h0;

	// Command register bit positions (write-only pulses)
	localparam int CMD_BEGIN_BIT = 0;
	localparam int CMD_END_BIT   = 1;
	localparam int CMD_CLR_BIT   = 2;

	// Measurement identifiers
	localparam logic [7:0] MEAS_ID_POWER   = 8'h22;
	localparam logic [7:0] MEAS_ID_PFACTOR = 8'hA6;
	localparam logic [7:0] MEAS_ID_ENERGY  = 8'hC8;

	// Reset values
	localparam logic [31:0] MIN_PAUSE_RESET = 32'h0000_0000;
	localparam logic [31:0] MAX_PAUSE_RESET = 32'hFFFF_FFFF;
	localparam logic [3:0]  INH_SEL_RESET   = 4'h0;

	// Interrupt event bit positions
	localparam int IRQ_BEGIN_BIT   = 0;
	localparam int IRQ_END_BIT     = 1;
	localparam int IRQ_IGNORED_BIT = 2;
	localparam int IRQ_REFUSE_BIT  = 3;
	localparam int IRQ_W           = 4;

	// Ordered drive state
	typedef enum logic [2:0] {
		DRV_SWITCH_ON_INHIBITED = 3'b000,
		DRV_READY_TO_START      = 3'b001,
		DRV_READY_STATE         = 3'b010,
		DRV_OPERATION_STATE     = 3'b011,
		DRV_FAULT               = 3'b100
	} eph_drive_e;

	typedef enum logic [1:0] {
		PS_PRODUCTIVE = 2'b00,
		PS_PAUSED     = 2'b01,
		PS_WAIT_STOP  = 2'b10
	} eph_pause_e;

	// Drive control outputs travel together
	typedef struct packed {
		logic ramp_stop_cmd;
		logic switch_on_block;
		logic force_inhibit;
		logic pulse_restart;
	} eph_drive_ctl_s;

	// Measurement inputs travel together
	typedef struct packed {
		logic [31:0] shaft_power_w;
		logic [31:0] power_factor;
		logic [31:0] energy_delta_wh;
	} eph_meas_s;
endpackage
`default_nettype wire

// ===== rtl/eph_energy_pause.sv
// Purpose: Energy pause command handler with APB registers
// Assumes: Commands arrive as acyclic register writes; single clock
// Notes:   Drive state is an input from the drive sequencer
`default_nettype none
module eph_energy_pause #(
	parameter int INH_SRC_W = 16
) (
	// APB
	input  wire logic                 pclk,
	input  wire logic                 presetn,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// Drive side
	input  wire eph_pkg::eph_drive_e  drive_state,
	input  wire logic [INH_SRC_W-1:0] inhibit_sources,
	input  wire eph_pkg::eph_meas_s   meas_in,
	input  wire logic                 energy_valid,
	output eph_pkg::eph_drive_ctl_s   drive_ctl,
	output logic                      energy_state_display,
	// Interrupt
	output logic                      irq
);
	localparam int IRQ_W_L = eph_pkg::IRQ_W;

	logic [2:0]             pause_response_config_r;
	logic [31:0]            pause_dur_r;
	logic [31:0]            min_pause_time_r;
	logic [31:0]            max_pause_time_r;
	logic [3:0]             inhibit_source_select_r;
	logic [31:0]            energy_acc_r;
	logic [7:0]             meas_id_r;
	logic [IRQ_W_L-1:0]     irq_stat_r;
	logic [IRQ_W_L-1:0]     irq_en_r;
	eph_pkg::eph_pause_e    pause_r;
	eph_pkg::eph_drive_ctl_s ctl_r;
	logic [31:0]            prdata_r;

	logic wr;
	logic rd;
	logic cmd_begin;
	logic cmd_end;
	logic cmd_clr;
	logic disabled;
	logic ramp_mode;
	logic s4_mode;
	logic stop_allowed;
	logic [IRQ_W_L-1:0] irq_evt;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
		return a == o;
	endfunction

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = prdata_r;

	assign cmd_begin = wr && hit(paddr, eph_pkg::OFF_COMMAND) &&
		pwdata[eph_pkg::CMD_BEGIN_BIT];
	assign cmd_end = wr && hit(paddr, eph_pkg::OFF_COMMAND) &&
		pwdata[eph_pkg::CMD_END_BIT] && !cmd_begin;
	assign cmd_clr = wr && hit(paddr, eph_pkg::OFF_COMMAND) &&
		pwdata[eph_pkg::CMD_CLR_BIT];

	assign disabled = pause_response_config_r[eph_pkg::CFG_DISABLE_BIT];
	assign ramp_mode = !disabled &&
		pause_response_config_r[eph_pkg::CFG_RAMP_BIT];
	assign s4_mode = pause_response_config_r[eph_pkg::CFG_S4_BIT];

	// Ordered state compare: S1/S2 below ready, S1..S4 up to operation
	always_comb begin
		if (s4_mode) begin
			stop_allowed = drive_state <= eph_pkg::DRV_OPERATION_STATE;
		end else begin
			stop_allowed = drive_state <= eph_pkg::DRV_READY_TO_START;
		end
	end

	// Configuration and settings
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_response_config_r <= eph_pkg::CFG_RESET;
			min_pause_time_r        <= eph_pkg::MIN_PAUSE_RESET;
			max_pause_time_r        <= eph_pkg::MAX_PAUSE_RESET;
			inhibit_source_select_r <= eph_pkg::INH_SEL_RESET;
			meas_id_r               <= 8'h00;
			irq_en_r                <= '0;
		end else if (wr) begin
			if (hit(paddr, eph_pkg::OFF_CONFIG)) begin
				pause_response_config_r <= pwdata[2:0];
			end else if (hit(paddr, eph_pkg::OFF_MIN_PAUSE)) begin
				min_pause_time_r <= pwdata;
			end else if (hit(paddr, eph_pkg::OFF_MAX_PAUSE)) begin
				max_pause_time_r <= pwdata;
			end else if (hit(paddr, eph_pkg::OFF_INH_SEL)) begin
				inhibit_source_select_r <= pwdata[3:0];
			end else if (hit(paddr, eph_pkg::OFF_MEAS_ID)) begin
				meas_id_r <= pwdata[7:0];
			end else if (hit(paddr, eph_pkg::OFF_IRQ_EN)) begin
				irq_en_r <= pwdata[IRQ_W_L-1:0];
			end
		end
	end

	// Pause duration captured on writes to the pause duration register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_dur_r <= 32'h0000_0000;
		end else if (wr && hit(paddr, eph_pkg::OFF_PAUSE_DUR)) begin
			pause_dur_r <= pwdata;
		end
	end

	// Pause state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pause_r <= eph_pkg::PS_PRODUCTIVE;
		end else if (disabled) begin
			pause_r <= eph_pkg::PS_PRODUCTIVE;
		end else begin
			case (pause_r)
				eph_pkg::PS_PRODUCTIVE: begin
					if (cmd_begin) begin
						if (ramp_mode && !stop_allowed) begin
							pause_r <= eph_pkg::PS_WAIT_STOP;
						end else begin
							pause_r <= eph_pkg::PS_PAUSED;
						end
					end
				end
				eph_pkg::PS_WAIT_STOP: begin
					if (cmd_end) begin
						pause_r <= eph_pkg::PS_PRODUCTIVE;
					end else if (!ramp_mode || stop_allowed) begin
						pause_r <= eph_pkg::PS_PAUSED;
					end
				end
				eph_pkg::PS_PAUSED: begin
					if (cmd_end) begin
						pause_r <= eph_pkg::PS_PRODUCTIVE;
					end
				end
				default: begin
					pause_r <= eph_pkg::PS_PRODUCTIVE;
				end
			endcase
		end
	end

	// Drive control outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctl_r <= '0;
		end else begin
			ctl_r.ramp_stop_cmd <= ramp_mode &&
				(pause_r == eph_pkg::PS_PAUSED);
			ctl_r.switch_on_block <= ramp_mode && !s4_mode &&
				(pause_r != eph_pkg::PS_PRODUCTIVE);
			ctl_r.force_inhibit <=
				inhibit_sources[inhibit_source_select_r];
			ctl_r.pulse_restart <= ramp_mode && s4_mode && cmd_end &&
				(pause_r == eph_pkg::PS_PAUSED) &&
				(drive_state == eph_pkg::DRV_READY_STATE ||
				 drive_state == eph_pkg::DRV_OPERATION_STATE);
		end
	end

	assign drive_ctl = ctl_r;

	// Energy state display
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_state_display <= 1'b0;
		end else begin
			energy_state_display <= !disabled &&
				(pause_r == eph_pkg::PS_PAUSED);
		end
	end

	// Energy balance accumulator
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			energy_acc_r <= 32'h0000_0000;
		end else if (cmd_clr) begin
			energy_acc_r <= 32'h0000_0000;
		end else if (energy_valid) begin
			energy_acc_r <= 32'(energy_acc_r + meas_in.energy_delta_wh);
		end
	end

	// Interrupt events: set wins over clear
	assign irq_evt[eph_pkg::IRQ_BEGIN_BIT]   = cmd_begin && !disabled;
	assign irq_evt[eph_pkg::IRQ_END_BIT]     = cmd_end && !disabled;
	assign irq_evt[eph_pkg::IRQ_IGNORED_BIT] =
		(cmd_begin || cmd_end) && disabled;
	assign irq_evt[eph_pkg::IRQ_REFUSE_BIT]  = cmd_begin && ramp_mode &&
		!stop_allowed && pause_r == eph_pkg::PS_PRODUCTIVE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= '0;
		end else if (wr && hit(paddr, eph_pkg::OFF_IRQ_CLR)) begin
			irq_stat_r <= (irq_stat_r & ~pwdata[IRQ_W_L-1:0]) | irq_evt;
		end else begin
			irq_stat_r <= irq_stat_r | irq_evt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	// Read data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd) begin
			if (hit(paddr, eph_pkg::OFF_CONFIG)) begin
				prdata_r <= {29'h0, pause_response_config_r};
			end else if (hit(paddr, eph_pkg::OFF_STATUS)) begin
				prdata_r <= {30'h0, pause_r};
			end else if (hit(paddr, eph_pkg::OFF_PAUSE_DUR)) begin
				prdata_r <= pause_dur_r;
			end else if (hit(paddr, eph_pkg::OFF_MIN_PAUSE)) begin
				prdata_r <= min_pause_time_r;
			end else if (hit(paddr, eph_pkg::OFF_MAX_PAUSE)) begin
				prdata_r <= max_pause_time_r;
			end else if (hit(paddr, eph_pkg::OFF_INH_SEL)) begin
				prdata_r <= {28'h0, inhibit_source_select_r};
			end else if (hit(paddr, eph_pkg::OFF_POWER)) begin
				prdata_r <= meas_in.shaft_power_w;
			end else if (hit(paddr, eph_pkg::OFF_PFACTOR)) begin
				prdata_r <= meas_in.power_factor;
			end else if (hit(paddr, eph_pkg::OFF_ENERGY)) begin
				prdata_r <= energy_acc_r;
			end else if (hit(paddr, eph_pkg::OFF_MEAS_ID)) begin
				prdata_r <= {24'h0, meas_id_r};
			end else if (hit(paddr, eph_pkg::OFF_MEAS_VAL)) begin
				if (meas_id_r == eph_pkg::MEAS_ID_POWER) begin
					prdata_r <= meas_in.shaft_power_w;
				end else if (meas_id_r == eph_pkg::MEAS_ID_PFACTOR) begin
					prdata_r <= meas_in.power_factor;
				end else if (meas_id_r == eph_pkg::MEAS_ID_ENERGY) begin
					prdata_r <= energy_acc_r;
				end else begin
					prdata_r <= 32'h0000_0000;
				end
			end else if (hit(paddr, eph_pkg::OFF_IRQ_STAT)) begin
				prdata_r <= {{(32-IRQ_W_L){1'b0}}, irq_stat_r};
			end else if (hit(paddr, eph_pkg::OFF_IRQ_EN)) begin
				prdata_r <= {{(32-IRQ_W_L){1'b0}}, irq_en_r};
			end else begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/eph_energy_pause_props.sv
// Purpose: Port properties of the pause handler
// Assumes: One clock, async active-low reset
// Notes:   Config and irq enable shadowed from APB writes
`default_nettype none
module eph_energy_pause_props #(
	parameter int INH_SRC_W = 16
) (
	// APB
	input wire logic                 pclk,
	input wire logic                 presetn,
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic                 pwrite,
	input wire logic [7:0]           paddr,
	input wire logic [31:0]          pwdata,
	input wire logic [31:0]          prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Drive side
	input wire eph_pkg::eph_drive_e  drive_state,
	input wire logic [INH_SRC_W-1:0] inhibit_sources,
	input wire eph_pkg::eph_meas_s   meas_in,
	input wire logic                 energy_valid,
	input wire eph_pkg::eph_drive_ctl_s drive_ctl,
	input wire logic                 energy_state_display,
	input wire logic                 irq
);
	logic [2:0] cfg_r;
	logic [3:0] ien_r;
	wire logic  wr = psel && penable && pwrite;
	wire logic  cw = wr && paddr == eph_pkg::OFF_COMMAND;
	wire logic  beg_w = cw && pwdata[0];
	wire logic  end_w = cw && pwdata[1:0] == 2'h2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) cfg_r <= 3'h0;
		else if (wr && paddr == eph_pkg::OFF_CONFIG) cfg_r <= pwdata[2:0];
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ien_r <= 4'h0;
		else if (wr && paddr == eph_pkg::OFF_IRQ_EN) ien_r <= pwdata[3:0];
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_stop;
		##[1:3] drive_ctl.ramp_stop_cmd;
	endsequence
	AST_ZERO_WAIT: assert property (pready && !pslverr)
		else $error("apb answer not zero wait");
	AST_IGNORED: assert property (
		beg_w && cfg_r[0] |=> !energy_state_display [*3])
		else $error("pause shown while disabled");
	AST_SHOW: assert property (
		beg_w && (cfg_r == 3'h0 || (cfg_r == 3'h6 && drive_state <= 3'h3))
		|-> ##[1:3] energy_state_display) else $error("pause not shown");
	AST_UNSHOW: assert property (
		end_w && !cfg_r[0] |-> ##[1:3] !energy_state_display)
		else $error("pause end not shown");
	AST_STOP_NOW: assert property (
		beg_w && cfg_r[1:0] == 2'h2 && drive_state <= 3'h1 |-> s_stop)
		else $error("ramp stop late in idle states");
	AST_STOP_ANY: assert property (
		beg_w && cfg_r == 3'h6 && drive_state <= 3'h3 |-> s_stop)
		else $error("ramp stop late in run mode");
	AST_STOP_OFF: assert property (
		end_w && cfg_r == 3'h2 |-> ##[1:3] !drive_ctl.ramp_stop_cmd)
		else $error("ramp stop kept after end");
	AST_RESTART: assert property (
		drive_ctl.pulse_restart |-> ($past(end_w) || $past(end_w, 2)
		|| $past(end_w, 3)) ##1 !drive_ctl.pulse_restart)
		else $error("restart pulse without end");
	AST_NO_AUTO: assert property (
		cfg_r == 3'h0 [*4] |-> !drive_ctl.ramp_stop_cmd
		&& !drive_ctl.switch_on_block) else $error("automatic stop");
	AST_BLOCK: assert property (drive_ctl.switch_on_block |->
		cfg_r == 3'h2 || $past(cfg_r) == 3'h2 || $past(cfg_r, 2) == 3'h2)
		else $error("switch-on blocked in wrong mode");
	AST_IRQ_MASK: assert property (
		irq |-> $past(ien_r) != 4'h0 || $past(ien_r, 2) != 4'h0)
		else $error("irq while masked");
endmodule
`default_nettype wire

// ===== verif/eph_drive_model.sv
// Purpose: Drive sequencer seen by the pause handler
// Assumes: Bench names the wanted state
// Notes:   Switch-on is held back while blocked
`default_nettype none
module eph_drive_model (
	// Clock and reset
	input  wire logic                    pclk,
	input  wire logic                    presetn,
	// Request and converter control
	input  wire eph_pkg::eph_drive_e     want,
	input  wire eph_pkg::eph_drive_ctl_s ctl,
	// State to the converter
	output eph_pkg::eph_drive_e          drive_state
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			drive_state <= eph_pkg::DRV_SWITCH_ON_INHIBITED;
		else if (ctl.force_inhibit)
			drive_state <= eph_pkg::DRV_SWITCH_ON_INHIBITED;
		else if (!(ctl.switch_on_block && want > 3'h1))
			drive_state <= want;
	end
endmodule
`default_nettype wire

// ===== verif/eph_energy_pause_command_handler_bench.sv
// Purpose: Self-checking bench of the pause handler
// Assumes: Zero-wait APB, drive state from model
// Notes:   Each scenario is one task
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("unexpected %s exp %0h got %0h", n, e, g); end end
module eph_energy_pause_command_handler_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    pclk, presetn, psel, penable, pwrite, ev;
	logic                    pready, pslverr, irq, esd, saw;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata, q;
	logic [15:0]             inh;
	eph_pkg::eph_drive_e     ds, want;
	eph_pkg::eph_meas_s      meas;
	eph_pkg::eph_drive_ctl_s ctl;
	int                      fails, n_compared;
	eph_energy_pause uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .drive_state(ds),
		.inhibit_sources(inh), .meas_in(meas), .energy_valid(ev),
		.drive_ctl(ctl), .energy_state_display(esd), .irq);
	eph_drive_model drv (.pclk, .presetn, .want, .ctl, .drive_state(ds));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) if (ctl.pulse_restart === 1'b1) saw <= 1'b1;
	task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e, string n);
		xf(1'b0, a, 32'h0);
		`CHK(n, e, q)
	endtask
	task automatic cmd(input logic [31:0] d);
		xf(1'b1, eph_pkg::OFF_COMMAND, d);
		repeat (2) @(posedge pclk);
	endtask
	task automatic go(input eph_pkg::eph_drive_e s);
		want <= s;
		repeat (4) @(posedge pclk);
	endtask
	task automatic t_regs;
		rc(eph_pkg::OFF_MAX_PAUSE, 32'hFFFF_FFFF, "max");
		xf(1'b1, eph_pkg::OFF_MIN_PAUSE, 32'h0000_1234);
		rc(eph_pkg::OFF_MIN_PAUSE, 32'h0000_1234, "min");
		xf(1'b1, eph_pkg::OFF_PAUSE_DUR, 32'h0000_0050);
		rc(eph_pkg::OFF_PAUSE_DUR, 32'h0000_0050, "dur");
		rc(8'h3C, 32'h0, "hole");
		$display("regs done");
	endtask
	task automatic t_show;
		xf(1'b1, eph_pkg::OFF_IRQ_EN, 32'h1);
		cmd(32'h1);
		rc(eph_pkg::OFF_STATUS, 32'h1, "status");
		`CHK("disp", 1'b1, esd)
		`CHK("ramp", 1'b0, ctl.ramp_stop_cmd)
		`CHK("irq", 1'b1, irq)
		xf(1'b1, eph_pkg::OFF_IRQ_CLR, 32'hF);
		@(posedge pclk);
		`CHK("irq", 1'b0, irq)
		cmd(32'h2);
		rc(eph_pkg::OFF_STATUS, 32'h0, "status");
		$display("show done");
	endtask
	task automatic t_off;
		for (int c = 1; c < 8; c += 2) begin
			xf(1'b1, eph_pkg::OFF_CONFIG, 32'(c));
			xf(1'b1, eph_pkg::OFF_IRQ_CLR, 32'hF);
			cmd(32'h1);
			rc(eph_pkg::OFF_STATUS, 32'h0, "status");
			rc(eph_pkg::OFF_IRQ_STAT, 32'h4, "ignored");
		end
		$display("off done");
	endtask
	task automatic t_ramp;
		xf(1'b1, eph_pkg::OFF_CONFIG, 32'h2);
		cmd(32'h1);
		`CHK("ramp", 1'b1, ctl.ramp_stop_cmd)
		go(eph_pkg::DRV_OPERATION_STATE);
		`CHK("refused", eph_pkg::DRV_SWITCH_ON_INHIBITED, ds)
		cmd(32'h2);
		`CHK("ramp", 1'b0, ctl.ramp_stop_cmd)
		go(eph_pkg::DRV_OPERATION_STATE);
		cmd(32'h1);
		rc(eph_pkg::OFF_STATUS, 32'h2, "wait");
		rc(eph_pkg::OFF_IRQ_STAT, 32'hF, "deferred");
		`CHK("ramp", 1'b0, ctl.ramp_stop_cmd)
		go(eph_pkg::DRV_READY_TO_START);
		`CHK("ramp", 1'b1, ctl.ramp_stop_cmd)
		cmd(32'h2);
		$display("ramp done");
	endtask
	task automatic t_run;
		xf(1'b1, eph_pkg::OFF_CONFIG, 32'h6);
		go(eph_pkg::DRV_OPERATION_STATE);
		cmd(32'h1);
		`CHK("ramp", 1'b1, ctl.ramp_stop_cmd)
		saw = 1'b0;
		cmd(32'h2);
		`CHK("restart", 1'b1, saw)
		go(eph_pkg::DRV_READY_TO_START);
		cmd(32'h1);
		saw = 1'b0;
		cmd(32'h2);
		`CHK("restart", 1'b0, saw)
		$display("run done");
	endtask
	task automatic t_meas;
		logic [7:0]  id[4] = '{8'h22, 8'hA6, 8'hC8, 8'h23};
		logic [31:0] ex[4] = '{32'h1F4, 32'h55, 32'h20, 32'h0};
		meas <= '{32'h1F4, 32'h55, 32'h10};
		ev <= 1'b1;
		repeat (2) @(posedge pclk);
		ev <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			xf(1'b1, eph_pkg::OFF_MEAS_ID, {24'h0, id[i]});
			rc(eph_pkg::OFF_MEAS_VAL, ex[i], "meas");
		end
		cmd(32'h4);
		rc(eph_pkg::OFF_ENERGY, 32'h0, "clear");
		xf(1'b1, eph_pkg::OFF_INH_SEL, 32'h3);
		inh <= 16'h0008;
		repeat (3) @(posedge pclk);
		`CHK("inhibit", 1'b1, ctl.force_inhibit)
		$display("meas done");
	endtask
	task automatic close_out;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, ev, saw} = '0;
		{paddr, pwdata, inh, meas} = '0;
		want = eph_pkg::DRV_SWITCH_ON_INHIBITED;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs();
		t_show();
		t_off();
		t_ramp();
		t_run();
		t_meas();
		close_out();
	end
	initial begin
		repeat (3000) @(posedge pclk);
		fails++;
		close_out();
	end
endmodule
bind eph_energy_pause eph_energy_pause_props #(.INH_SRC_W(INH_SRC_W)) u_p (
	.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
	.pready, .pslverr, .drive_state, .inhibit_sources, .meas_in,
	.energy_valid, .drive_ctl, .energy_state_display, .irq);
`default_nettype wire
